// ### hw/slu_pkg.sv
// Shared constants and types of the single-level interrupt unit.
package slu_pkg;

  // ******************************************************
  // Register map, byte offsets on the AXI4-Lite bus
  // ******************************************************
  localparam int         ADDR_W               = 5;
  localparam logic [4:0] OFF_CTRL             = 5'h00;
  localparam logic [4:0] OFF_PORT_WAKE_EN     = 5'h04;
  localparam logic [4:0] OFF_PORT_EDGE_SEL    = 5'h08;
  localparam logic [4:0] OFF_PORT_PEND        = 5'h0c;
  localparam logic [4:0] OFF_COUNTER          = 5'h10;
  localparam logic [4:0] OFF_TIMER1_CONTROL_B = 5'h14;
  localparam logic [4:0] OFF_UNIT_STATE       = 5'h18;

  // ******************************************************
  // Field positions and values after reset
  // ******************************************************
  localparam int         CTR_IRQ_EN_N_BIT     = 0;
  localparam int         CTR_OVF_BIT          = 7;
  localparam int         PAGE_SELECT_BIT0     = 5;
  localparam int         PAGE_SELECT_BIT1     = 6;
  localparam int         PAGE_SELECT_BIT2     = 7;
  localparam logic [7:0] RST_CTRL             = 8'h01;
  localparam logic [7:0] RST_PORT_WAKE_EN     = 8'h00;
  localparam logic [7:0] RST_PORT_EDGE_SEL    = 8'h00;
  localparam logic [7:0] RST_COUNTER          = 8'h00;
  localparam logic [11:0] VECTOR_ADDR         = 12'h000;
  localparam logic [1:0] RESP_OKAY            = 2'h0;
  localparam logic [1:0] RESP_SLVERR          = 2'h2;

  // ******************************************************
  // Response latency in instruction cycles (one per mclk)
  // ******************************************************
  localparam int         LAT_COUNTER_CYC      = 3;
  localparam int         LAT_PORT_CYC         = 5;
  localparam logic [2:0] WAIT_COUNTER         = 3'(LAT_COUNTER_CYC - 3);
  localparam logic [2:0] WAIT_PORT            = 3'(LAT_PORT_CYC - 3);

  // Sequencer states, one-hot.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_WAIT    = 3'h2,
    ST_SERVICE = 3'h4
  } slu_state_e;

endpackage

// ### hw/slu_port_wake.sv
// Port wakeup edge detector with per-pin sticky pending flags.
`timescale 1ns/1ps
module slu_port_wake #(
  parameter int WIDTH = 8
) (
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  input  wire logic [WIDTH-1:0] pinsAsync,
  input  wire logic [WIDTH-1:0] edgeFall,
  input  wire logic [WIDTH-1:0] wakeEn,
  input  wire logic [WIDTH-1:0] clrMask,
  output logic      [WIDTH-1:0] pend
);

  logic [WIDTH-1:0] syncA;
  logic [WIDTH-1:0] syncB;
  logic [WIDTH-1:0] prevB;
  logic [WIDTH-1:0] hit;
  logic [WIDTH-1:0] next_pend;

  // Edge selection per pin; a set in the same cycle as a clear wins.
  always_comb begin
    hit       = wakeEn & ((syncB & ~prevB & ~edgeFall) | (~syncB & prevB & edgeFall));
    next_pend = (pend & ~clrMask) | hit;
  end

  // Two-stage synchroniser, history stage and pending flags.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      syncA <= '0;
      syncB <= '0;
      prevB <= '0;
      pend  <= '0;
    end else begin
      syncA <= pinsAsync;
      syncB <= syncA;
      prevB <= syncB;
      pend  <= next_pend;
    end
  end

endmodule // slu_port_wake

// ### hw/slu_irq_unit.sv
// Single-level interrupt unit: sources, context shadows, sequencer, AXI4-Lite registers.
// Function
// - Save PC, accumulator, status, pointer to shadows.
// - Vector every entry to address zero.
// - Block new entries until return.
// - Clear page bits after status saved.
// - Interrupt return address kept apart from call stack.
// - No priority; pending sources taken one by one.
// - Port flags keep setting during service.
// - Return restores context from shadows.
// - Pending request re-enters right after return.
// - Latency: counter three, port five cycles.
// - Only enabled sources request entry.
// - Port edges never interrupt in power-down.
// - Counter wrap FFh to 00h requests.
// - Larger variant sets overflow flag bit seven.
// - Add-return adds accumulator to counter first.
// - Eight pins, edge select, own pending flags.
//
// Local design decisions: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module slu_irq_unit #(
  parameter int WIDTH       = 8,
  parameter bit HAS_OVF_FLAG = 1'b1
) (
  input  wire logic                      mclk,
  input  wire logic                      sys_rst,
  input  wire logic [slu_pkg::ADDR_W-1:0] awaddr,
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  input  wire logic                      wvalid,
  output logic                           wready,
  output logic      [1:0]                bresp,
  output logic                           bvalid,
  input  wire logic                      bready,
  input  wire logic [slu_pkg::ADDR_W-1:0] araddr,
  input  wire logic                      arvalid,
  output logic                           arready,
  output logic      [31:0]               rdata,
  output logic      [1:0]                rresp,
  output logic                           rvalid,
  input  wire logic                      rready,
  input  wire logic [WIDTH-1:0]          portPins,
  input  wire logic                      sleepMode,
  input  wire logic                      counterTick,
  input  wire logic                      retiReq,
  input  wire logic                      retiAdd,
  input  wire logic [11:0]               pcIn,
  input  wire logic [7:0]                accIn,
  input  wire logic [7:0]                statusIn,
  input  wire logic [7:0]                fsrIn,
  output logic                           vectorJump,
  output logic                           restoreLoad,
  output logic      [11:0]               pcLoadValue,
  output logic      [7:0]                accLoadValue,
  output logic      [7:0]                statusLoadValue,
  output logic      [7:0]                fsrLoadValue,
  output logic                           inService,
  output logic      [7:0]                counterValue
);

  // ******************************************************
  // Declarations
  // ******************************************************
  slu_pkg::slu_state_e         state, next_state;
  logic [2:0]                  waitCnt, next_waitCnt;
  logic                        ctrReq, next_ctrReq;
  logic                        lastPort, next_lastPort;
  logic                        ovfFlag, next_ovfFlag;
  logic [11:0]                 shadowPc, next_shadowPc;
  logic [7:0]                  shadowAcc, next_shadowAcc;
  logic [7:0]                  shadowStatus, next_shadowStatus;
  logic [7:0]                  shadowFsr, next_shadowFsr;
  logic                        next_vectorJump, next_restoreLoad, next_inService;
  logic [11:0]                 next_pcLoadValue;
  logic [7:0]                  next_accLoadValue, next_statusLoadValue, next_fsrLoadValue;
  logic [7:0]                  next_counterValue;
  logic [7:0]                  ctrl, next_ctrl;
  logic [WIDTH-1:0]            wakeEn, next_wakeEn;
  logic [WIDTH-1:0]            edgeSel, next_edgeSel;
  logic [WIDTH-1:0]            portPend;
  logic [WIDTH-1:0]            pendClr;
  logic                        awHave, next_awHave, wHave, next_wHave;
  logic [slu_pkg::ADDR_W-1:0]  awAddrQ, next_awAddrQ;
  logic [31:0]                 wDataQ, next_wDataQ;
  logic [3:0]                  wStrbQ, next_wStrbQ;
  logic                        next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0]                  next_bresp, next_rresp;
  logic [31:0]                 next_rdata;
  logic                        doWrite, wrCounter, wrOvfClr, retiAccept, retiAddTake;
  logic                        ctrWrap, portReq, canStart, takeCtr, takePort, go;

  // Write hit on a register whose low byte lane is enabled.
  function automatic logic wrHit(input logic [slu_pkg::ADDR_W-1:0] off);
    wrHit = doWrite && (awAddrQ == off) && wStrbQ[0];
  endfunction

  // True when an offset belongs to the register map.
  function automatic logic isMapped(input logic [slu_pkg::ADDR_W-1:0] a);
    isMapped = (a == slu_pkg::OFF_CTRL) || (a == slu_pkg::OFF_PORT_WAKE_EN)
            || (a == slu_pkg::OFF_PORT_EDGE_SEL) || (a == slu_pkg::OFF_PORT_PEND)
            || (a == slu_pkg::OFF_COUNTER) || (a == slu_pkg::OFF_TIMER1_CONTROL_B)
            || (a == slu_pkg::OFF_UNIT_STATE);
  endfunction

  // ******************************************************
  // Port wakeup pending flags
  // ******************************************************
  // Detection runs regardless of the sequencer, so edges seen in service stay pending.
  slu_port_wake #(
    .WIDTH (WIDTH)
  ) u_port_wake (
    .mclk      (mclk),
    .sys_rst   (sys_rst),
    .pinsAsync (portPins),
    .edgeFall  (edgeSel),
    .wakeEn    (wakeEn),
    .clrMask   (pendClr),
    .pend      (portPend)
  );

  // ******************************************************
  // Request sources and selection
  // ******************************************************
  // Source qualification, source choice and the start condition.
  always_comb begin
    retiAccept  = (state == slu_pkg::ST_SERVICE) && retiReq;
    retiAddTake = retiAccept && retiAdd;
    ctrWrap     = counterTick && (counterValue == 8'hff) && !wrCounter && !retiAddTake;
    portReq     = (|(portPend & wakeEn)) && !sleepMode;
    canStart    = (state == slu_pkg::ST_IDLE) || retiAccept;
    takePort    = canStart && portReq && (!ctrReq || !lastPort);
    takeCtr     = canStart && ctrReq && !takePort;
    go          = takePort || takeCtr;
  end

  // ******************************************************
  // Counter, sequencer and context shadows
  // ******************************************************
  // Next values of the counter, request latch, sequencer and core load outputs.
  always_comb begin
    next_state           = state;
    next_waitCnt         = waitCnt;
    next_lastPort        = lastPort;
    next_shadowPc        = shadowPc;
    next_shadowAcc       = shadowAcc;
    next_shadowStatus    = shadowStatus;
    next_shadowFsr       = shadowFsr;
    next_vectorJump      = 1'b0;
    next_restoreLoad     = 1'b0;
    next_pcLoadValue     = pcLoadValue;
    next_accLoadValue    = accLoadValue;
    next_statusLoadValue = statusLoadValue;
    next_fsrLoadValue    = fsrLoadValue;
    // The counter: bus write first, then add-return, then the tick.
    next_counterValue = counterValue;
    if (wrCounter) begin
      next_counterValue = wDataQ[7:0];
    end else if (retiAddTake) begin
      next_counterValue = counterValue + accIn;
    end else if (counterTick) begin
      next_counterValue = counterValue + 8'h01;
    end
    // A new wrap wins over the clear caused by taking the request.
    next_ctrReq  = (ctrReq && !takeCtr) || (ctrWrap && !ctrl[slu_pkg::CTR_IRQ_EN_N_BIT]);
    next_ovfFlag = HAS_OVF_FLAG && ((ovfFlag && !wrOvfClr) || ctrWrap);
    unique case (state)
      slu_pkg::ST_IDLE: begin
        if (go) begin
          next_state = slu_pkg::ST_WAIT;
        end
      end
      slu_pkg::ST_WAIT: begin
        if (waitCnt == 3'h0) begin
          // Entry: shadows take the live context, page bits are cleared only in the load value.
          // Just after a return the core still shows the routine's context for one
          // cycle, so a quick retake keeps the shadows, which hold the restored one.
          next_state           = slu_pkg::ST_SERVICE;
          next_vectorJump      = 1'b1;
          if (!restoreLoad) begin
            next_shadowPc     = pcIn;
            next_shadowAcc    = accIn;
            next_shadowStatus = statusIn;
            next_shadowFsr    = fsrIn;
          end
          next_pcLoadValue     = slu_pkg::VECTOR_ADDR;
          next_accLoadValue    = next_shadowAcc;
          next_statusLoadValue = next_shadowStatus;
          next_statusLoadValue[slu_pkg::PAGE_SELECT_BIT0] = 1'b0;
          next_statusLoadValue[slu_pkg::PAGE_SELECT_BIT1] = 1'b0;
          next_statusLoadValue[slu_pkg::PAGE_SELECT_BIT2] = 1'b0;
          next_fsrLoadValue    = next_shadowFsr;
        end else begin
          next_waitCnt = waitCnt - 3'h1;
        end
      end
      slu_pkg::ST_SERVICE: begin
        if (retiAccept) begin
          next_restoreLoad     = 1'b1;
          next_pcLoadValue     = shadowPc;
          next_accLoadValue    = shadowAcc;
          next_statusLoadValue = shadowStatus;
          next_fsrLoadValue    = shadowFsr;
          next_state           = go ? slu_pkg::ST_WAIT : slu_pkg::ST_IDLE;
        end
      end
    endcase
    if (go) begin
      next_waitCnt  = takeCtr ? slu_pkg::WAIT_COUNTER : slu_pkg::WAIT_PORT;
      next_lastPort = takePort;
    end
    next_inService = (next_state == slu_pkg::ST_SERVICE);
  end

  // Registers of the sequencer group.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state           <= slu_pkg::ST_IDLE;
      waitCnt         <= 3'h0;
      ctrReq          <= 1'b0;
      lastPort        <= 1'b0;
      ovfFlag         <= 1'b0;
      shadowPc        <= 12'h000;
      shadowAcc       <= 8'h00;
      shadowStatus    <= 8'h00;
      shadowFsr       <= 8'h00;
      vectorJump      <= 1'b0;
      restoreLoad     <= 1'b0;
      pcLoadValue     <= 12'h000;
      accLoadValue    <= 8'h00;
      statusLoadValue <= 8'h00;
      fsrLoadValue    <= 8'h00;
      inService       <= 1'b0;
      counterValue    <= slu_pkg::RST_COUNTER;
    end else begin
      state           <= next_state;
      waitCnt         <= next_waitCnt;
      ctrReq          <= next_ctrReq;
      lastPort        <= next_lastPort;
      ovfFlag         <= next_ovfFlag;
      shadowPc        <= next_shadowPc;
      shadowAcc       <= next_shadowAcc;
      shadowStatus    <= next_shadowStatus;
      shadowFsr       <= next_shadowFsr;
      vectorJump      <= next_vectorJump;
      restoreLoad     <= next_restoreLoad;
      pcLoadValue     <= next_pcLoadValue;
      accLoadValue    <= next_accLoadValue;
      statusLoadValue <= next_statusLoadValue;
      fsrLoadValue    <= next_fsrLoadValue;
      inService       <= next_inService;
      counterValue    <= next_counterValue;
    end
  end

  // ******************************************************
  // AXI4-Lite slave
  // ******************************************************
  // Address and data are caught in either order; the write runs once both are held.
  always_comb begin
    doWrite   = awHave && wHave && !bvalid;
    wrCounter = wrHit(slu_pkg::OFF_COUNTER);
    wrOvfClr  = wrHit(slu_pkg::OFF_TIMER1_CONTROL_B) && wDataQ[slu_pkg::CTR_OVF_BIT];
    pendClr   = wrHit(slu_pkg::OFF_PORT_PEND) ? wDataQ[WIDTH-1:0] : '0;
    next_ctrl    = wrHit(slu_pkg::OFF_CTRL) ? (wDataQ[7:0] & 8'h01) : ctrl;
    next_wakeEn  = wrHit(slu_pkg::OFF_PORT_WAKE_EN) ? wDataQ[WIDTH-1:0] : wakeEn;
    next_edgeSel = wrHit(slu_pkg::OFF_PORT_EDGE_SEL) ? wDataQ[WIDTH-1:0] : edgeSel;
    next_awHave  = (awHave || (awvalid && awready)) && !doWrite;
    next_wHave   = (wHave || (wvalid && wready)) && !doWrite;
    next_awAddrQ = (awvalid && awready) ? awaddr : awAddrQ;
    next_wDataQ  = (wvalid && wready) ? wdata : wDataQ;
    next_wStrbQ  = (wvalid && wready) ? wstrb : wStrbQ;
    next_bvalid  = doWrite || (bvalid && !bready);
    next_awready = !next_awHave && !next_bvalid;
    next_wready  = !next_wHave && !next_bvalid;
    next_bresp   = doWrite ? (isMapped(awAddrQ) ? slu_pkg::RESP_OKAY : slu_pkg::RESP_SLVERR)
                           : bresp;
    next_rvalid  = (arvalid && arready) || (rvalid && !rready);
    next_arready = !next_rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (arvalid && arready) begin
      next_rresp = isMapped(araddr) ? slu_pkg::RESP_OKAY : slu_pkg::RESP_SLVERR;
      next_rdata = 32'h0;
      unique case (araddr)
        slu_pkg::OFF_CTRL:             next_rdata[7:0] = ctrl;
        slu_pkg::OFF_PORT_WAKE_EN:     next_rdata[WIDTH-1:0] = wakeEn;
        slu_pkg::OFF_PORT_EDGE_SEL:    next_rdata[WIDTH-1:0] = edgeSel;
        slu_pkg::OFF_PORT_PEND:        next_rdata[WIDTH-1:0] = portPend;
        slu_pkg::OFF_COUNTER:          next_rdata[7:0] = counterValue;
        slu_pkg::OFF_TIMER1_CONTROL_B: next_rdata[slu_pkg::CTR_OVF_BIT] = ovfFlag;
        slu_pkg::OFF_UNIT_STATE:       next_rdata[3:0] = {ctrReq, state};
        default:                       next_rdata = 32'h0;
      endcase
    end
  end

  // Registers of the bus group.
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl    <= slu_pkg::RST_CTRL;
      wakeEn  <= slu_pkg::RST_PORT_WAKE_EN;
      edgeSel <= slu_pkg::RST_PORT_EDGE_SEL;
      awHave  <= 1'b0;
      wHave   <= 1'b0;
      awAddrQ <= '0;
      wDataQ  <= 32'h0;
      wStrbQ  <= 4'h0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= slu_pkg::RESP_OKAY;
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0;
      rresp   <= slu_pkg::RESP_OKAY;
    end else begin
      ctrl    <= next_ctrl;
      wakeEn  <= next_wakeEn;
      edgeSel <= next_edgeSel;
      awHave  <= next_awHave;
      wHave   <= next_wHave;
      awAddrQ <= next_awAddrQ;
      wDataQ  <= next_wDataQ;
      wStrbQ  <= next_wStrbQ;
      awready <= next_awready;
      wready  <= next_wready;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      arready <= next_arready;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // ******************************************************
  // Assertions
  // ******************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);

  // Entry starts for each source.
  sequence s_ctrStart;
    takeCtr;
  endsequence
  sequence s_portStart;
    takePort;
  endsequence

  a_ctr_latency: assert property (s_ctrStart |-> !vectorJump ##1 !vectorJump ##1 vectorJump)
    else $error("counter entry not at third cycle");
  a_port_latency: assert property (s_portStart |-> !vectorJump[*4] ##0 1'b1 ##1 vectorJump)
    else $error("port entry not at fifth cycle");
  a_vector_zero: assert property (vectorJump |-> pcLoadValue == 12'h000 && inService)
    else $error("entry did not vector to zero");
  a_save_ctx: assert property (vectorJump |-> ($past(restoreLoad)
      ? ($stable(shadowPc) && $stable(shadowAcc) && $stable(shadowFsr))
      : (shadowPc == $past(pcIn) && shadowAcc == $past(accIn) && shadowFsr == $past(fsrIn))))
    else $error("context not saved on entry");
  a_page_clear: assert property (vectorJump |-> statusLoadValue[7:5] == 3'h0
      && statusLoadValue[4:0] == shadowStatus[4:0]
      && shadowStatus == ($past(restoreLoad) ? $past(shadowStatus) : $past(statusIn)))
    else $error("page bits not cleared after save");
  a_no_reentry: assert property ((state == slu_pkg::ST_SERVICE && !retiReq) |=> state == slu_pkg::ST_SERVICE && !vectorJump)
    else $error("entry while in service");
  a_restore_ctx: assert property (retiAccept |=> restoreLoad && pcLoadValue == $past(shadowPc) && statusLoadValue == $past(shadowStatus))
    else $error("context not restored on return");
  a_retake_now: assert property ((retiAccept && (ctrReq || portReq)) |=> state == slu_pkg::ST_WAIT)
    else $error("pending request not retaken");
  a_sleep_block: assert property ((sleepMode && !ctrReq && canStart) |-> !go)
    else $error("port edge entered in power-down");
  a_return_add_to_counter_add: assert property ((retiAddTake && !wrCounter) |=> counterValue == 8'($past(counterValue) + $past(accIn)))
    else $error("add-return did not add accumulator");

endmodule // slu_irq_unit

// ### testbench/slu_core_model.sv
// Behavioural model of the processor core that follows the unit's context loads.
`timescale 1ns/1ps
module slu_core_model (
  input  wire logic        mclk,
  input  wire logic        ldCtx,
  input  wire logic [35:0] ctxSeed,
  input  wire logic        vectorJump,
  input  wire logic        restoreLoad,
  input  wire logic        inService,
  input  wire logic [35:0] loadCtx,
  output logic      [35:0] ctx
);
  // Context is pc, accumulator, status, pointer; idle code spins in place.
  // The service routine moves pc and the accumulator so a lost restore shows.
  always @(posedge mclk) begin
    if (ldCtx) ctx <= ctxSeed;
    else if (vectorJump || restoreLoad) ctx <= loadCtx;
    else if (inService) ctx <= ctx + {12'h001, 8'h01, 16'h0000};
  end
endmodule // slu_core_model

// ### testbench/tb.sv
// Self-checking bench of the single-level interrupt unit.
`timescale 1ns/1ps
module tb;
  logic        mclk = 1'b0, sys_rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, sleepMode = 1'b0, counterTick = 1'b0;
  logic        retiReq = 1'b0, retiAdd = 1'b0, ldCtx = 1'b1;
  logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [7:0]  portPins = 8'h00, counterValue, addExp;
  logic [35:0] ctx, ctxSeed, savedCtx;
  wire  [35:0] loadCtx;
  logic        awready, wready, bvalid, arready, rvalid, vectorJump, restoreLoad, inService;
  logic [1:0]  bresp, rresp;
  int          errors = 0, n_checks = 0, cyc = 0, vjCount = 0, vjAt = 0, tickAt = 0, retAt = 0;
  int          rlCount = 0;

  always #2.5 mclk = ~mclk;

  slu_irq_unit dut (.mclk(mclk), .sys_rst(sys_rst), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .portPins(portPins), .sleepMode(sleepMode), .counterTick(counterTick),
    .retiReq(retiReq), .retiAdd(retiAdd), .pcIn(ctx[35:24]), .accIn(ctx[23:16]),
    .statusIn(ctx[15:8]), .fsrIn(ctx[7:0]), .vectorJump(vectorJump),
    .restoreLoad(restoreLoad), .pcLoadValue(loadCtx[35:24]), .accLoadValue(loadCtx[23:16]),
    .statusLoadValue(loadCtx[15:8]), .fsrLoadValue(loadCtx[7:0]), .inService(inService),
    .counterValue(counterValue));

  slu_core_model core (.mclk(mclk), .ldCtx(ldCtx), .ctxSeed(ctxSeed),
    .vectorJump(vectorJump), .restoreLoad(restoreLoad), .inService(inService),
    .loadCtx(loadCtx), .ctx(ctx));

  // Compares a seen value with the expected one and counts both outcomes.
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // One register write; address and data are released as each is taken.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    check(bresp, (a > slu_pkg::OFF_UNIT_STATE) ? slu_pkg::RESP_SLVERR : slu_pkg::RESP_OKAY);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  // One register read, returning data and response code.
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge mclk);
  endtask

  // One counter tick followed by a quiet cycle.
  task automatic tick();
    counterTick <= 1'b1;
    @(posedge mclk);
    counterTick <= 1'b0;
    @(posedge mclk);
  endtask

  // One return instruction, plain or adding the accumulator to the counter.
  task automatic reti(input logic add);
    retiReq <= 1'b1;
    retiAdd <= add;
    @(posedge mclk);
    retiReq <= 1'b0;
    retiAdd <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask

  // Watches entries and returns and checks what is handed to the core.
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (counterTick === 1'b1) tickAt <= cyc;
    if (retiReq === 1'b1 && inService === 1'b1) begin
      retAt <= cyc - 1; // The return cycle began one edge earlier.
      addExp <= retiAdd ? counterValue + ctx[23:16] : counterValue;
    end
    if (vectorJump === 1'b1) begin
      vjCount <= vjCount + 1;
      vjAt <= cyc;
      savedCtx <= ctx;
      check(loadCtx[35:24], 36'h0);
      check(loadCtx[15:8], {31'h0, ctx[12:8]});
      check(inService, 36'h1);
    end
    if (restoreLoad === 1'b1) begin
      rlCount <= rlCount + 1;
      check(loadCtx, savedCtx);
      check(counterValue, addExp);
    end
  end

  // Cuts a hung run short.
  initial begin
    repeat (5000) @(posedge mclk);
    errors++;
    results();
  end

  // Main sequence of tests.
  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          p;
    p = $urandom(32'hd4ca5688);
    p = $urandom_range(7, 0);
    ctxSeed = 36'({$urandom(), $urandom()});
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0;
    ldCtx <= 1'b0;
    @(posedge mclk);
    rd(slu_pkg::OFF_CTRL, d, r);
    check(d, slu_pkg::RST_CTRL);
    rd(5'h1c, d, r);
    check(r, slu_pkg::RESP_SLVERR);
    wr(5'h1c, 8'hff);
    $display("test registers done");
    wr(slu_pkg::OFF_COUNTER, 8'hff);
    tick();
    repeat (8) @(posedge mclk);
    check(vjCount, 36'h0);
    rd(slu_pkg::OFF_TIMER1_CONTROL_B, d, r);
    check(d[7], 36'h1);
    wr(slu_pkg::OFF_TIMER1_CONTROL_B, 8'h80);
    rd(slu_pkg::OFF_TIMER1_CONTROL_B, d, r);
    check(d[7], 36'h0);
    $display("test disabled counter done");
    wr(slu_pkg::OFF_CTRL, 8'h00);
    wr(slu_pkg::OFF_COUNTER, 8'hfe);
    tick();
    tick();
    repeat (6) @(posedge mclk);
    check(vjCount, 36'h1);
    check(vjAt - tickAt, slu_pkg::LAT_COUNTER_CYC);
    wr(slu_pkg::OFF_PORT_WAKE_EN, 8'h01 << p);
    portPins[p] <= 1'b1;
    repeat (12) @(posedge mclk);
    check(vjCount, 36'h1);
    rd(slu_pkg::OFF_PORT_PEND, d, r);
    check(d, 32'h1 << p);
    reti(1'b1);
    check(vjCount, 36'h2);
    check(vjAt - retAt, slu_pkg::LAT_PORT_CYC);
    wr(slu_pkg::OFF_PORT_PEND, 8'hff);
    reti(1'b0);
    check(vjCount, 36'h2);
    $display("test counter and return done");
    wr(slu_pkg::OFF_PORT_EDGE_SEL, 8'hff);
    sleepMode <= 1'b1;
    portPins[p] <= 1'b0;
    repeat (10) @(posedge mclk);
    check(vjCount, 36'h2);
    wr(slu_pkg::OFF_PORT_PEND, 8'hff);
    sleepMode <= 1'b0;
    portPins[p] <= 1'b1;
    repeat (10) @(posedge mclk);
    check(vjCount, 36'h2);
    portPins[p] <= 1'b0;
    repeat (12) @(posedge mclk);
    check(vjCount, 36'h3);
    wr(slu_pkg::OFF_PORT_PEND, 8'hff);
    wr(slu_pkg::OFF_COUNTER, 8'hff);
    tick();
    reti(1'b0);
    check(vjCount, 36'h4);
    check(vjAt - retAt, slu_pkg::LAT_COUNTER_CYC);
    reti(1'b0);
    check(vjCount, 36'h4);
    check(rlCount, 36'h4);
    $display("test port edges done");
    results();
  end
endmodule // tb
